// [design/dvs_mode_and_ramp_control.sv]
// DVS profile selection, switching-mode control and voltage-code ramping.
// Assumes an AXI4-Lite master on aclk and asynchronous pins from outside.
//
// Function
// (R01) Four profiles each hold 6-bit voltage code
// (R02) Each profile stores mode and sync enable
// (R03) Select pins pick profile by two-bit index
// (R04) Reset defaults 1.40/1.00/1.40/1.10 V, power save
// (R05) Select pulldowns disabled by control bit
// (R06) Enable pulldown disabled by control bit
// (R07) Enable low holds control at default
// (R08) Regulator on while enable high
// (R09) Mode writable anytime, even active profile
// (R10) Over 16 crossings enables hysteretic bias
// (R11) Biased and over 24 crossings enters hysteretic
// (R12) Under 16 crossings biases fixed-frequency path
// (R13) Biased and under 8 resumes fixed frequency
// (R14) Forced mode switches at constant rate
// (R15) Sync divides external clock by 4/6/8
// (R16) One code step per period times 2^ramp
// (R17) Power save without decay: no active down-ramp
// (R18) Power save with decay: comparator off ramping down
// (R19) Forced mode always ramps down actively
// (R20) Rectifier off at cycle end or near-zero; the code acts on near-zero only in power save
// (R21) Full soft start on every enable
// (R22) Active profile writes apply at write acknowledge
// (R23) Thermal shutdown keeps registers and bus
// (R24) Profile change adopts settings, ramps to target
// (R25) Cycle without crossing clears the count
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "dvs_defs.svh"
module dvs_mode_and_ramp_control
  import dvs_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock, reset and freeze
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Pins and analog indications
  input wire logic en_pin,
  input wire logic profile_select_lsb,
  input wire logic profile_select_msb,
  input wire logic ext_clk,
  input wire logic zero_cross,
  input wire logic near_zero_current,
  input wire logic thermal_shutdown,
  input wire logic hyst_bias_ready,
  input wire logic pwm_bias_ready,
  // Converter controls
  output logic regulator_on,
  output vcode_t vout_code,
  output logic forced_pwm,
  output logic sync_active,
  output logic switch_tick,
  output logic hyst_bias_en,
  output logic pwm_bias_en,
  output logic hyst_active,
  output logic lowside_off,
  output logic zc_comp_enable,
  output logic soft_start_active,
  // Pulldown controls
  output logic en_pulldown_on,
  output logic sel_pulldown_on
);

  // Register index decode: {valid, index}
  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    case (b)
      `OFS_PROFILE0: decode = 4'h8;
      `OFS_PROFILE1: decode = 4'h9;
      `OFS_PROFILE2: decode = 4'ha;
      `OFS_PROFILE3: decode = 4'hb;
      `OFS_CONTROL: decode = 4'hc;
      `OFS_RAMP: decode = 4'hd;
      `OFS_STATUS: decode = 4'he;
      default: decode = 4'h0;
    endcase
  endfunction

  logic [8:0] pin_meta;
  logic [8:0] pin_sync;
  logic en_s, lsb_s, msb_s, ext_s, zc_s, nz_s, therm_s, hrdy_s, prdy_s;
  logic ext_d;
  logic aw_hold, w_hold, w_en0, do_wr, wr_ok;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic [3:0] wdec, rdec;
  logic [7:0] prof [4];
  logic [1:0] ctrl;
  logic [5:0] ramp;
  logic [1:0] sel;
  logic [7:0] act;
  vcode_t target;
  logic ps, sync_en, decay, reg_on, on_d;
  logic [3:0] div_n;
  logic [7:0] sw_cnt, step_cnt, step_lim;
  logic step_due, ramp_down;
  logic zc_seen, zc_live;
  logic [4:0] zc_cnt;
  op_state_e state, next_state;
  logic [31:0] next_rdata;

  // Two-flop synchronisers on every pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta <= 9'h000;
      pin_sync <= 9'h000;
      ext_d <= 1'b0;
    end
    else if (ce)
    begin
      pin_meta <= {pwm_bias_ready, hyst_bias_ready, thermal_shutdown, near_zero_current,
                   zero_cross, ext_clk, profile_select_msb, profile_select_lsb, en_pin};
      pin_sync <= pin_meta;
      ext_d <= ext_s;
    end
  end
  assign {prdy_s, hrdy_s, therm_s, nz_s, zc_s, ext_s, msb_s, lsb_s, en_s} = pin_sync;

  // Write address and data taken in either order
  assign awready = !aw_hold;
  assign wready = !w_hold;
  assign wdec = decode(aw_addr);
  assign do_wr = aw_hold && w_hold && !bvalid;
  assign wr_ok = do_wr && wdec[3] && w_en0;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_en0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        aw_hold <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_hold <= 1'b1;
        w_byte <= wdata[7:0];
        w_en0 <= wstrb[0];
      end
      if (do_wr)
      begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wdec[3] ? 2'h0 : 2'h2; // Unmapped answers SLVERR
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // Profile registers; reset only by aresetn, so thermal events keep them
  for (genvar g = 0; g < 4; g++)
  begin : g_prof
    localparam logic [7:0] RST = (g == 0) ? `PROFILE0_RST : (g == 1) ? `PROFILE1_RST :
                                 (g == 2) ? `PROFILE2_RST : `PROFILE3_RST;
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        prof[g] <= RST; // [R04] [R23]
      else if (ce && wr_ok && wdec[2:0] == 3'(g))
        prof[g] <= w_byte; // [R01] [R02] [R09] [R22]
    end
  end

  // Control register, held at default while enable is low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl <= `CONTROL_RST;
    else if (ce)
    begin
      if (!en_s)
        ctrl <= `CONTROL_RST; // [R07]
      else if (wr_ok && wdec[2:0] == 3'h4)
        ctrl <= w_byte[1:0]; // [R05] [R06]
    end
  end
  assign en_pulldown_on = !ctrl[`CT_EN_PD_OFF]; // [R06]
  assign sel_pulldown_on = !ctrl[`CT_SEL_PD_OFF]; // [R05]

  // Ramp code, decay bit and sync divider select
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ramp <= `RAMP_RST;
    else if (ce && wr_ok && wdec[2:0] == 3'h5)
      ramp <= w_byte[5:0];
  end

  // Read data mux
  assign rdec = decode(araddr);
  always_comb
  begin
    next_rdata = 32'h0;
    case (rdec[2:0])
      3'h0, 3'h1, 3'h2, 3'h3: next_rdata = {24'h0, prof[rdec[1:0]]};
      3'h4: next_rdata = {30'h0, ctrl};
      3'h5: next_rdata = {26'h0, ramp};
      3'h6: next_rdata = {20'h0, on_d, ramp_down, 2'(state), sel, vout_code};
      default: next_rdata = 32'h0;
    endcase
  end

  // Read channel: one read at a time
  assign arready = !rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rdata <= next_rdata;
        rresp <= rdec[3] ? 2'h0 : 2'h2;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

  // Active profile follows the select pins at once
  assign sel = {msb_s, lsb_s}; // [R03] [R24]
  assign act = prof[sel];
  assign target = act[5:0];
  assign ps = !act[`PF_MODE_BIT];
  assign sync_en = act[`PF_SYNC_BIT];
  assign decay = ramp[`RP_DECAY_BIT];
  assign reg_on = en_s && !therm_s; // [R08] [R23]

  // Divider select for the external clock
  always_comb
  begin
    case (ramp[5:4])
      2'h0: div_n = `DIV_13M;
      2'h1: div_n = `DIV_19M2;
      default: div_n = `DIV_26M;
    endcase
  end

  // Switching cycle tick from internal rate or divided external clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sw_cnt <= 8'h00;
      switch_tick <= 1'b0;
    end
    else if (ce)
    begin
      switch_tick <= 1'b0;
      if (!reg_on)
        sw_cnt <= 8'h00;
      else if (sync_en)
      begin
        if (ext_s && !ext_d)
        begin
          if (sw_cnt >= {4'h0, div_n} - 8'h01)
          begin
            sw_cnt <= 8'h00;
            switch_tick <= 1'b1; // [R15]
          end
          else
            sw_cnt <= sw_cnt + 8'h01;
        end
      end
      else if (sw_cnt >= 8'(`INT_SW_CYCLES - 1))
      begin
        sw_cnt <= 8'h00;
        switch_tick <= 1'b1; // [R14]
      end
      else
        sw_cnt <= sw_cnt + 8'h01;
    end
  end

  // Consecutive zero-crossing counter
  assign zc_live = zc_s && zc_comp_enable;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      zc_seen <= 1'b0;
      zc_cnt <= 5'h00;
    end
    else if (ce)
    begin
      if (!on_d)
      begin
        zc_seen <= 1'b0;
        zc_cnt <= 5'h00;
      end
      else if (switch_tick)
      begin
        zc_seen <= 1'b0;
        if (!(zc_seen || zc_live))
          zc_cnt <= 5'h00; // [R25]
        else if (zc_cnt != 5'h1f)
          zc_cnt <= zc_cnt + 5'h01;
      end
      else if (zc_live)
        zc_seen <= 1'b1;
    end
  end

  // Fixed-frequency and hysteretic transitions
  always_comb
  begin
    next_state = state;
    case (state)
      st_ff_run:
        if (ps && zc_cnt > `ZC_HYST_BIAS)
          next_state = st_hyst_bias; // [R10]
      st_hyst_bias:
        if (!ps || zc_cnt < `ZC_HYST_BIAS)
          next_state = st_ff_run;
        else if (hrdy_s && zc_cnt > `ZC_HYST_RUN)
          next_state = st_hyst_run; // [R11]
      st_hyst_run:
        if (!ps)
          next_state = st_ff_run; // [R14]
        else if (zc_cnt < `ZC_HYST_BIAS)
          next_state = st_ff_bias; // [R12]
      st_ff_bias:
        if (!ps || (prdy_s && zc_cnt < `ZC_FF_RUN))
          next_state = st_ff_run; // [R13]
      default: next_state = st_ff_run;
    endcase
  end

  // Operating state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state <= st_ff_run;
    else if (ce)
      state <= on_d ? next_state : st_ff_run;
  end
  assign hyst_bias_en = (state == st_hyst_bias) || (state == st_hyst_run);
  assign pwm_bias_en = (state != st_hyst_run);
  assign hyst_active = (state == st_hyst_run) || (state == st_ff_bias);

  // Ramp step pacing: one step every 2^code switching cycles
  assign step_lim = (8'h01 << ramp[2:0]) - 8'h01;
  assign step_due = switch_tick && (step_cnt >= step_lim); // [R16]
  assign ramp_down = on_d && (vout_code > target) && (!ps || decay); // [R19]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      step_cnt <= 8'h00;
    else if (ce)
    begin
      if (!on_d)
        step_cnt <= 8'h00;
      else if (switch_tick)
        step_cnt <= step_due ? 8'h00 : step_cnt + 8'h01;
    end
  end

  // Output voltage code; starts from zero on every enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      vout_code <= 6'h00;
    else if (ce)
    begin
      if (!reg_on)
        vout_code <= 6'h00; // [R21]
      else if (vout_code < target)
      begin
        if (step_due)
          vout_code <= vout_code + 6'h01; // [R16] [R24]
      end
      else if (vout_code > target)
      begin
        if (ps && !decay)
          vout_code <= target; // [R17]
        else if (step_due)
          vout_code <= vout_code - 6'h01; // [R19]
      end
    end
  end

  // Registered converter controls
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      on_d <= 1'b0;
      soft_start_active <= 1'b0;
      lowside_off <= 1'b0;
      zc_comp_enable <= 1'b1;
      forced_pwm <= 1'b0;
      sync_active <= 1'b0;
    end
    else if (ce)
    begin
      on_d <= reg_on;
      if (reg_on && !on_d)
        soft_start_active <= 1'b1; // [R21]
      else if (!reg_on || vout_code == target)
        soft_start_active <= 1'b0;
      lowside_off <= on_d && (switch_tick || (ps && nz_s)); // [R20]
      zc_comp_enable <= !(ps && decay && ramp_down); // [R18]
      forced_pwm <= !ps; // [R09] [R24]
      sync_active <= sync_en && on_d;
    end
  end
  assign regulator_on = on_d;

  a_ctrl_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
    ce && !en_s |=> ctrl == `CONTROL_RST && en_pulldown_on && sel_pulldown_on)
    else $error("control not held at default");
  a_hyst_entry: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
    ce && on_d && state == st_hyst_bias && ps && hrdy_s && zc_cnt > `ZC_HYST_RUN
    |=> state == st_hyst_run)
    else $error("hysteretic entry missed");
  a_bias_entry: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
    ce && on_d && state == st_ff_run && ps && zc_cnt > `ZC_HYST_BIAS
    |=> hyst_bias_en)
    else $error("hysteretic bias not enabled");
  a_zc_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [R25]
    ce && on_d && switch_tick && !zc_seen && !zc_live |=> zc_cnt == 5'h00)
    else $error("zero-cross count not cleared");
  a_passive_decay: assert property (@(posedge aclk) disable iff (!aresetn) // [R17]
    ce && reg_on && ps && !decay && vout_code > target |=> vout_code == $past(target))
    else $error("passive decay not applied");
  a_ramp_step: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
    ce && reg_on && step_due && vout_code < target |=> vout_code == $past(vout_code) + 6'h01)
    else $error("ramp step missing");
  a_zc_off: assert property (@(posedge aclk) disable iff (!aresetn) // [R18]
    ce && ps && decay && ramp_down |=> !zc_comp_enable)
    else $error("comparator not disabled");
  a_lowside_end: assert property (@(posedge aclk) disable iff (!aresetn) // [R20]
    ce && on_d && switch_tick |=> lowside_off)
    else $error("rectifier not turned off");
  a_forced_exit: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
    ce && on_d && !ps |=> state == st_ff_run ##1 !hyst_active)
    else $error("forced mode left hysteretic");
endmodule

// [design/dvs_defs.svh]
// Offsets, field positions, reset values and timing counts of the DVS control block.
// Included by the package user; holds definitions only.
`ifndef DVS_DEFS_SVH
`define DVS_DEFS_SVH
// Register byte offsets
`define OFS_PROFILE0 8'h00
`define OFS_PROFILE1 8'h04
`define OFS_PROFILE2 8'h08
`define OFS_PROFILE3 8'h0c
`define OFS_CONTROL 8'h10
`define OFS_RAMP 8'h14
`define OFS_STATUS 8'h18
// Profile fields: [5:0] voltage code, mode bit, sync bit
`define PF_MODE_BIT 6
`define PF_SYNC_BIT 7
// Control fields: pulldown disables
`define CT_EN_PD_OFF 0
`define CT_SEL_PD_OFF 1
// Ramp fields: [2:0] ramp code, decay bit, [5:4] sync divider select
`define RP_DECAY_BIT 3
// Voltage code: 0.77 V at code zero, 10 mV per code
`define VOUT_MIN_MV 770
`define VOUT_LSB_MV 10
// Reset values: power save, sync off; 1.40 V, 1.00 V, 1.40 V, 1.10 V
`define PROFILE0_RST 8'h3f
`define PROFILE1_RST 8'h17
`define PROFILE2_RST 8'h3f
`define PROFILE3_RST 8'h21
`define CONTROL_RST 2'h0
`define RAMP_RST 6'h00
// Internal switching clock and system clock
`define CLK_KHZ 40000
`define INT_FSW_KHZ 3250
`define INT_SW_CYCLES (`CLK_KHZ / `INT_FSW_KHZ)
// External clock dividers for 13, 19.2 and 26 MHz
`define DIV_13M 4'h4
`define DIV_19M2 4'h6
`define DIV_26M 4'h8
// Zero-crossing thresholds
`define ZC_HYST_BIAS 5'h10
`define ZC_HYST_RUN 5'h18
`define ZC_FF_RUN 5'h08
`endif

// [design/dvs_pkg.sv]
// Types shared by the DVS control block.
// Assumes nothing beyond the defs header.
package dvs_pkg;
  typedef enum logic [1:0] {st_ff_run, st_hyst_bias, st_hyst_run, st_ff_bias} op_state_e;
  typedef logic [5:0] vcode_t;
endpackage

// [bench/host_model.sv]
// Host partner: AXI4-Lite master tasks and the enable and profile-select pin drivers.
// Assumes one clock; every change lands by non-blocking assignment after a rising edge.
`timescale 1ns/10ps
module host_model
(
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  // Pins
  output logic en_pin,
  output logic profile_select_lsb,
  output logic profile_select_msb
);
  // Idle bus, regulator off, profile zero selected
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, en_pin, profile_select_lsb, profile_select_msb} = '0;
  end
  // Enable and profile index pins
  task automatic pins(input logic en, input logic [1:0] sel);
    @(posedge aclk);
    en_pin <= en;
    {profile_select_msb, profile_select_lsb} <= sel;
  endtask
  // One write; a released payload is inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hf};
    {awvalid, wvalid, bready} <= 3'b111;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) {awvalid, awaddr} <= {1'b0, ~a};
      if (wvalid && wready) {wvalid, wdata, wstrb} <= {1'b0, ~d, 4'h0};
    end
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  // One read; data and response taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) {arvalid, araddr} <= {1'b0, ~a};
    end
    while (rvalid !== 1'b1);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask
endmodule

// [bench/dvs_mode_and_ramp_control_tb.sv]
// Self-checking bench for the DVS mode and ramp control block.
// Assumes the host partner model and the design header on the include path.
`timescale 1ns/10ps
`include "dvs_defs.svh"
module dvs_mode_and_ramp_control_tb
  import dvs_pkg::*;
;
  typedef struct {logic [7:0] a; logic [31:0] d;} row_s;
  logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
  logic arready, rvalid, rready, en_pin, profile_select_lsb, profile_select_msb, ext_clk;
  logic zero_cross, near_zero_current, thermal_shutdown, hyst_bias_ready, pwm_bias_ready;
  logic regulator_on, forced_pwm, sync_active, switch_tick, hyst_bias_en, pwm_bias_en;
  logic hyst_active, lowside_off, zc_comp_enable, soft_start_active;
  logic en_pulldown_on, sel_pulldown_on;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [3:0] divs[3];
  logic [1:0] bresp, rresp, r;
  vcode_t vout_code;
  row_s rows[7];
  int err_count, samples_checked, cyc, n, z;
  // Design and host partner
  dvs_mode_and_ramp_control DUT
  (
    .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .en_pin, .profile_select_lsb, .profile_select_msb, .ext_clk, .zero_cross,
    .near_zero_current, .thermal_shutdown, .hyst_bias_ready, .pwm_bias_ready, .regulator_on,
    .vout_code, .forced_pwm, .sync_active, .switch_tick, .hyst_bias_en, .pwm_bias_en,
    .hyst_active, .lowside_off, .zc_comp_enable, .soft_start_active, .en_pulldown_on,
    .sel_pulldown_on
  );
  host_model host
  (
    .aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .en_pin,
    .profile_select_lsb, .profile_select_msb
  );
  // 40 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Free-running external clock at half rate, and the run limit
  always @(posedge aclk)
  begin
    ext_clk <= ~ext_clk;
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_count++;
      finish_test();
    end
  end
  function automatic logic [31:0] mv(input int v);
    return (v - `VOUT_MIN_MV) / `VOUT_LSB_MV;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One settled sample, counting switching ticks
  task automatic step();
    @(negedge aclk);
    if (switch_tick === 1'b1) n++;
  endtask
  // Stop at a settled sample that shows a tick
  task automatic sync_tick();
    @(negedge aclk);
    for (int i = 0; i < 99 && switch_tick !== 1'b1; i++) @(negedge aclk);
  endtask
  // Cycles from one tick to the next, left in n
  task automatic gap();
    sync_tick();
    @(negedge aclk);
    for (n = 1; n < 99 && switch_tick !== 1'b1; n++) @(negedge aclk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic finish_test();
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {aresetn, ce, ext_clk, zero_cross, near_zero_current} = 5'b01000;
    {thermal_shutdown, hyst_bias_ready, pwm_bias_ready} = 3'b000;
    {err_count, samples_checked, cyc} = '0;
    divs = '{4'h4, 4'h6, 4'h8};
    rows = '{'{`OFS_PROFILE0, mv(1400)}, '{`OFS_PROFILE1, mv(1000)},
      '{`OFS_PROFILE2, mv(1400)}, '{`OFS_PROFILE3, mv(1100)}, '{`OFS_CONTROL, 0},
      '{`OFS_RAMP, 0}, '{`OFS_STATUS, 0}};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i])
    begin
      host.rd(rows[i].a, d, r);
      chk(d, rows[i].d);
      chk(r, 2'h0);
    end
    host.wr(8'h20, 32'h0, r);
    chk(r, 2'h2);
    host.rd(8'h20, d, r);
    chk(r, 2'h2);
    done("reset values");
    // Enable: soft start climbs from the bottom code to profile zero
    host.pins(1'b1, 2'd0);
    repeat (8) @(negedge aclk);
    chk(soft_start_active, 1'b1);
    chk(regulator_on, 1'b1);
    // Clock enable low freezes the climbing code
    @(posedge aclk);
    ce <= 1'b0;
    @(negedge aclk);
    d = vout_code;
    repeat (30) @(negedge aclk);
    chk(vout_code, d);
    @(posedge aclk);
    ce <= 1'b1;
    for (int i = 0; i < 1500 && vout_code !== mv(1400); i++) @(negedge aclk);
    chk(vout_code, mv(1400));
    repeat (2) @(negedge aclk);
    chk(soft_start_active, 1'b0);
    gap();
    chk(n, `INT_SW_CYCLES);
    host.pins(1'b1, 2'd1);
    repeat (8) @(negedge aclk);
    chk(vout_code, mv(1000));
    chk(forced_pwm, 1'b0);
    done("enable and select");
    // Unbroken crossings lead into hysteretic operation and back out
    sync_tick();
    @(posedge aclk);
    zero_cross <= 1'b1;
    hyst_bias_ready <= 1'b1;
    n = 0;
    for (int i = 0; i < 900 && hyst_bias_en !== 1'b1; i++) step();
    chk(n, 17);
    for (int i = 0; i < 900 && hyst_active !== 1'b1; i++) step();
    chk(n, 25);
    sync_tick();
    @(posedge aclk);
    zero_cross <= 1'b0;
    n = 0;
    for (int i = 0; i < 200 && pwm_bias_en !== 1'b1; i++) step();
    chk(n, 2);
    @(posedge aclk);
    pwm_bias_ready <= 1'b1;
    for (int i = 0; i < 60 && hyst_active !== 1'b0; i++) @(negedge aclk);
    chk(hyst_active, 1'b0);
    done("zero crossing");
    // Forced mode on the live profile, then stepped ramps down and up
    host.wr(`OFS_PROFILE1, 32'h40 | mv(1000), r);
    repeat (3) @(negedge aclk);
    chk(forced_pwm, 1'b1);
    sync_tick();
    host.wr(`OFS_PROFILE1, 32'h40 | mv(930), r);
    n = 0;
    for (int i = 0; i < 900 && vout_code !== mv(930); i++) step();
    chk(n, 7);
    host.wr(`OFS_RAMP, 32'h1, r);
    sync_tick();
    host.wr(`OFS_PROFILE1, 32'h40 | mv(1000), r);
    n = 0;
    for (int i = 0; i < 900 && vout_code !== mv(1000); i++) step();
    chk((n + 1) / 2, 7);
    // Power save with active decay keeps the comparator off while stepping down
    host.wr(`OFS_RAMP, 32'h8, r);
    host.wr(`OFS_PROFILE1, mv(930), r);
    z = 0;
    for (int i = 0; i < 900 && vout_code !== mv(930); i++)
    begin
      @(negedge aclk);
      if (zc_comp_enable === 1'b0) z++;
    end
    chk(z > 40, 1'b1);
    repeat (3) @(negedge aclk);
    chk(zc_comp_enable, 1'b1);
    // Near-zero current turns the rectifier off in power save
    @(posedge aclk);
    near_zero_current <= 1'b1;
    repeat (4) @(negedge aclk);
    chk(lowside_off, 1'b1);
    done("ramping");
    // External clock dividers
    host.wr(`OFS_PROFILE1, 32'hc0 | mv(930), r);
    for (int k = 0; k < 3; k++)
    begin
      host.wr(`OFS_RAMP, k << 4, r);
      gap();
      gap();
      chk(n, 2 * divs[k]);
    end
    chk(lowside_off, 1'b0);
    @(negedge aclk);
    chk(lowside_off, 1'b1);
    chk(sync_active, 1'b1);
    done("sync");
    // Pulldowns, thermal shutdown and enable low
    host.wr(`OFS_CONTROL, 32'h3, r);
    repeat (2) @(negedge aclk);
    chk(en_pulldown_on, 1'b0);
    chk(sel_pulldown_on, 1'b0);
    @(posedge aclk);
    thermal_shutdown <= 1'b1;
    repeat (6) @(negedge aclk);
    chk(regulator_on, 1'b0);
    host.rd(`OFS_PROFILE1, d, r);
    chk(d, 32'hc0 | mv(930));
    thermal_shutdown <= 1'b0;
    host.pins(1'b0, 2'd1);
    repeat (6) @(negedge aclk);
    chk(en_pulldown_on, 1'b1);
    chk(sel_pulldown_on, 1'b1);
    chk(regulator_on, 1'b0);
    host.wr(`OFS_CONTROL, 32'h3, r);
    host.rd(`OFS_CONTROL, d, r);
    chk(d, 32'h0);
    host.rd(`OFS_STATUS, d, r);
    chk(d, 32'h40);
    done("pins");
    finish_test();
  end
endmodule
